// file: eccsc_ctrl.sv
`timescale 1ns/10ps

// Behaviour
// - The command holds a 7-bit operation code whose upper three bits pick the class, class zero being primitive arithmetic.
// - In class zero the low code selects reserved, add, subtract, odd-modulus multiply, odd-modulus divide or plain multiply.
// - Class three selects the high-level operations, low code zero being the second part of the key agreement.
// - In class three low code one is proof verification, two is domain parameter validation, others are reserved.
// - Classes four to seven are reserved and select no operation.
// - The launch bit is active high and sampled on the rising clock edge.
// - A rising launch bit starts the command currently held in the command register.
// - A launch while busy is ignored and the running command is not altered.
// - The launch bit clears itself when the operation completes.
// - A read-only busy flag is high while processing and low once the operation finishes.
// - The field bit selects a prime field when zero and a binary field when one.
// - An eight-bit field gives the operand length in 64-bit double words.
// - For a non-reserved operation, a set recalculation bit makes the block recompute the Montgomery constant first and then clear the bit.
module eccsc_ctrl #(
  parameter int CYCLES_PER_WORD = eccsc_pkg::CYCLES_PER_WORD,
  parameter int RECALC_CYCLES = eccsc_pkg::RECALC_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Launch toward the arithmetic core
  output eccsc_pkg::eccsc_launch_t opLaunch,
  output logic busy,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    eccsc_pkg::eccsc_cmd_t cmd;
    logic launch;
    eccsc_pkg::eccsc_state_t state;
    logic [15:0] cnt;
    eccsc_pkg::eccsc_cmd_t work;
    logic [1:0] irqStat;
    logic [1:0] irqMask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    eccsc_pkg::eccsc_launch_t launchOut;
    logic busy;
    logic irq;
  } eccsc_regs_t;

  logic [1:0] rstSync;
  logic rstnSys;
  eccsc_regs_t s_r;
  eccsc_regs_t s_nxt;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstnSys = rstSync[1];

  ////////////////////////////////////////////////////////////////////////////

  function automatic eccsc_pkg::eccsc_op_t decodeOp(input logic [6:0] code);
    eccsc_pkg::eccsc_op_t k;
    k = eccsc_pkg::OP_RESERVED;
    if (code[6:4] == eccsc_pkg::CLASS_PRIMITIVE) begin
      case (code[3:0])
        eccsc_pkg::PRIM_ADD: k = eccsc_pkg::OP_MOD_ADD;
        eccsc_pkg::PRIM_SUB: k = eccsc_pkg::OP_MOD_SUB;
        eccsc_pkg::PRIM_MUL: k = eccsc_pkg::OP_MOD_MUL;
        eccsc_pkg::PRIM_DIV: k = eccsc_pkg::OP_MOD_DIV;
        eccsc_pkg::PRIM_PLAIN_MUL: k = eccsc_pkg::OP_MULT;
        default: k = eccsc_pkg::OP_RESERVED;
      endcase
    end else if (code[6:4] == eccsc_pkg::CLASS_HIGH_LEVEL) begin
      case (code[3:0])
        eccsc_pkg::HL_ECMQV2: k = eccsc_pkg::OP_ECMQV2;
        eccsc_pkg::HL_ZKP: k = eccsc_pkg::OP_ZKP_VERIFY;
        eccsc_pkg::HL_DOMAIN: k = eccsc_pkg::OP_DOMAIN_CHECK;
        default: k = eccsc_pkg::OP_RESERVED;
      endcase
    end
    // Classes 1, 2 and 4..7 stay reserved
    return k;
  endfunction : decodeOp

  // Execution length; empty length runs one word
  function automatic logic [15:0] execCycles(input logic [7:0] len);
    logic [15:0] words;
    words = (len == 8'h00) ? 16'h0001 : {8'h00, len};
    return 16'((32'(words) * CYCLES_PER_WORD));
  endfunction : execCycles

  ////////////////////////////////////////////////////////////////////////////

  logic access;
  logic wrCmd;
  logic wrLaunch;
  logic wrIrqStat;
  logic wrIrqMask;
  logic mapped;
  logic launchReq;
  logic finish;
  logic [1:0] irqEvt;
  eccsc_pkg::eccsc_cmd_t wcmd;

  always_comb begin
    s_nxt = s_r;
    access = psel && penable && s_r.pready;
    mapped = (paddr == eccsc_pkg::ADDR_COMMAND) || (paddr == eccsc_pkg::ADDR_LAUNCH) ||
      (paddr == eccsc_pkg::ADDR_STATUS) || (paddr == eccsc_pkg::ADDR_IRQ_STAT) ||
      (paddr == eccsc_pkg::ADDR_IRQ_MASK);
    wrCmd = access && pwrite && (paddr == eccsc_pkg::ADDR_COMMAND);
    wrLaunch = access && pwrite && (paddr == eccsc_pkg::ADDR_LAUNCH) && pstrb[0];
    wrIrqStat = access && pwrite && (paddr == eccsc_pkg::ADDR_IRQ_STAT) && pstrb[0];
    wrIrqMask = access && pwrite && (paddr == eccsc_pkg::ADDR_IRQ_MASK) && pstrb[0];
    launchReq = wrLaunch && pwdata[eccsc_pkg::LAUNCH_BIT];
    finish = 1'b0;
    irqEvt = 2'h0;
    s_nxt.launchOut.opStart = 1'b0;

    // Command register with byte lanes
    wcmd = s_r.cmd;
    if (wrCmd) begin
      if (pstrb[0]) begin
        wcmd.fieldBinary = pwdata[eccsc_pkg::CMD_FIELD_BIT];
        wcmd.operationCode = pwdata[6:0];
      end
      if (pstrb[1]) begin
        wcmd.operandLength = pwdata[eccsc_pkg::CMD_LEN_LSB +: 8];
      end
      if (pstrb[3]) begin
        wcmd.recalc = pwdata[eccsc_pkg::CMD_RECALC_BIT];
        wcmd.signB = pwdata[eccsc_pkg::CMD_SIGNB_BIT];
        wcmd.signA = pwdata[eccsc_pkg::CMD_SIGNA_BIT];
      end
    end
    s_nxt.cmd = wcmd;

    // Command sequencer
    case (s_r.state)
      eccsc_pkg::ST_IDLE: begin
        if (launchReq) begin
          s_nxt.launch = 1'b1;
          s_nxt.busy = 1'b1;
          s_nxt.work = s_r.cmd;
          s_nxt.launchOut.opStart = 1'b1;
          s_nxt.launchOut.opKind = decodeOp(s_r.cmd.operationCode);
          s_nxt.launchOut.opFieldBinary = s_r.cmd.fieldBinary;
          s_nxt.launchOut.opLength = s_r.cmd.operandLength;
          if (decodeOp(s_r.cmd.operationCode) == eccsc_pkg::OP_RESERVED) begin
            // Nothing to compute, leave memory alone
            s_nxt.state = eccsc_pkg::ST_EXEC;
            s_nxt.cnt = 16'h0001;
          end else if (s_r.cmd.recalc) begin
            s_nxt.state = eccsc_pkg::ST_RECALC;
            s_nxt.cnt = 16'(RECALC_CYCLES);
          end else begin
            s_nxt.state = eccsc_pkg::ST_EXEC;
            s_nxt.cnt = execCycles(s_r.cmd.operandLength);
          end
        end
      end
      eccsc_pkg::ST_RECALC: begin
        s_nxt.cnt = s_r.cnt - 16'h0001;
        if (s_r.cnt == 16'h0001) begin
          // Constant ready; a new set from software wins
          if (!(wrCmd && pstrb[3] && pwdata[eccsc_pkg::CMD_RECALC_BIT])) begin
            s_nxt.cmd.recalc = 1'b0;
          end
          s_nxt.state = eccsc_pkg::ST_EXEC;
          s_nxt.cnt = execCycles(s_r.work.operandLength);
        end
      end
      eccsc_pkg::ST_EXEC: begin
        s_nxt.cnt = s_r.cnt - 16'h0001;
        if (s_r.cnt == 16'h0001) begin
          finish = 1'b1;
        end
      end
      default: begin
        s_nxt.state = eccsc_pkg::ST_IDLE;
      end
    endcase

    // Completion clears launch and busy, posts the done event and, for a reserved operation, the reserved event
    if (finish) begin
      s_nxt.state = eccsc_pkg::ST_IDLE;
      s_nxt.launch = 1'b0;
      s_nxt.busy = 1'b0;
      irqEvt[eccsc_pkg::IRQ_DONE_BIT] = 1'b1;
      irqEvt[eccsc_pkg::IRQ_RSVD_BIT] = (s_r.launchOut.opKind == eccsc_pkg::OP_RESERVED);
    end

    // Sticky events, set wins over write-one-clear
    if (wrIrqStat) begin
      s_nxt.irqStat = s_r.irqStat & ~pwdata[1:0];
    end
    s_nxt.irqStat = s_nxt.irqStat | irqEvt;
    if (wrIrqMask) begin
      s_nxt.irqMask = pwdata[1:0];
    end
    s_nxt.irq = |(s_nxt.irqStat & s_nxt.irqMask);

    // APB answer in the access cycle
    s_nxt.pready = psel && !penable;
    s_nxt.pslverr = psel && !penable && !mapped;
    s_nxt.prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        eccsc_pkg::ADDR_COMMAND: begin
          s_nxt.prdata = {s_r.cmd.recalc, s_r.cmd.signB, s_r.cmd.signA, 13'h0000,
            s_r.cmd.operandLength, s_r.cmd.fieldBinary, s_r.cmd.operationCode};
        end
        eccsc_pkg::ADDR_LAUNCH: s_nxt.prdata = {31'h0000_0000, s_r.launch};
        eccsc_pkg::ADDR_STATUS: s_nxt.prdata[eccsc_pkg::STATUS_BUSY_BIT] = s_r.busy;
        eccsc_pkg::ADDR_IRQ_STAT: s_nxt.prdata = {30'h0000_0000, s_r.irqStat};
        eccsc_pkg::ADDR_IRQ_MASK: s_nxt.prdata = {30'h0000_0000, s_r.irqMask};
        default: s_nxt.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstnSys) begin
    if (!rstnSys) begin
      s_r <= '0;
      s_r.cmd <= {eccsc_pkg::COMMAND_RESET[31:29], eccsc_pkg::COMMAND_RESET[15:0]};
      s_r.launch <= eccsc_pkg::LAUNCH_RESET[eccsc_pkg::LAUNCH_BIT];
      s_r.state <= eccsc_pkg::ST_IDLE;
      s_r.launchOut.opKind <= eccsc_pkg::OP_RESERVED;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign opLaunch = s_r.launchOut;
  assign busy = s_r.busy;
  assign irq = s_r.irq;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstnSys);

  a_busy_tracks_state: assert property (
    busy == (s_r.state != eccsc_pkg::ST_IDLE)) else $error("busy differs from sequencer state");
  a_launch_starts_op: assert property (
    (launchReq && !busy) |=> busy && opLaunch.opStart && s_r.launch) else $error("launch did not start");
  a_busy_launch_ignored: assert property (
    (launchReq && busy && !finish) |=> !opLaunch.opStart && $stable(s_r.work)) else $error("busy launch acted");
  a_launch_self_clear: assert property (
    $fell(busy) |-> !s_r.launch && s_r.irqStat[eccsc_pkg::IRQ_DONE_BIT]) else $error("launch not cleared");
  a_reserved_quick_end: assert property (
    (opLaunch.opStart && opLaunch.opKind == eccsc_pkg::OP_RESERVED) |-> busy ##1 !busy)
    else $error("reserved op too long");
  a_class_reserved: assert property (
    (opLaunch.opStart && s_r.work.operationCode[6:4] >= eccsc_pkg::CLASS_FIRST_RESERVED)
    |-> opLaunch.opKind == eccsc_pkg::OP_RESERVED) else $error("reserved class decoded");
  a_prim_add_decode: assert property (
    (opLaunch.opStart && s_r.work.operationCode == {eccsc_pkg::CLASS_PRIMITIVE, eccsc_pkg::PRIM_ADD})
    |-> opLaunch.opKind == eccsc_pkg::OP_MOD_ADD) else $error("add misdecoded");
  a_high_zkp_decode: assert property (
    (opLaunch.opStart && s_r.work.operationCode == {eccsc_pkg::CLASS_HIGH_LEVEL, eccsc_pkg::HL_ZKP})
    |-> opLaunch.opKind == eccsc_pkg::OP_ZKP_VERIFY) else $error("proof op misdecoded");
  a_recalc_bit_clear: assert property (
    (s_r.state == eccsc_pkg::ST_RECALC && s_r.cnt == 16'h0001 && !wrCmd) |=> !s_r.cmd.recalc)
    else $error("recalc bit stuck");
  a_launch_fields_kept: assert property (
    opLaunch.opStart |-> opLaunch.opLength == $past(s_r.cmd.operandLength) &&
    opLaunch.opFieldBinary == $past(s_r.cmd.fieldBinary)) else $error("launch fields wrong");
  a_launch_cmd_copy: assert property (
    opLaunch.opStart |-> s_r.work == $past(s_r.cmd)) else $error("launch took a stale command");
  a_recalc_runs_first: assert property (
    (launchReq && !busy && s_r.cmd.recalc && decodeOp(s_r.cmd.operationCode) != eccsc_pkg::OP_RESERVED)
    |=> s_r.state == eccsc_pkg::ST_RECALC) else $error("recalc phase skipped");

  c_reserved_launch: cover property (opLaunch.opStart && opLaunch.opKind == eccsc_pkg::OP_RESERVED);
  c_recalc_run: cover property (s_r.state == eccsc_pkg::ST_RECALC ##1 s_r.state == eccsc_pkg::ST_EXEC);
  c_busy_launch: cover property (launchReq && busy);
  c_irq_raised: cover property ($rose(irq));

endmodule : eccsc_ctrl

// file: eccsc_pkg.sv
package eccsc_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_COMMAND = 32'h5000_6004;
  localparam logic [31:0] ADDR_LAUNCH = 32'h5000_6008;
  localparam logic [31:0] ADDR_STATUS = 32'h5000_600c;
  localparam logic [31:0] ADDR_IRQ_STAT = 32'h5000_6014;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h5000_6018;

  // Command, launch, status and interrupt register fields and reset values
  localparam int CMD_RECALC_BIT = 31;
  localparam int CMD_SIGNB_BIT = 30;
  localparam int CMD_SIGNA_BIT = 29;
  localparam int CMD_LEN_LSB = 8;
  localparam int CMD_FIELD_BIT = 7;
  localparam int LAUNCH_BIT = 0;
  localparam int STATUS_BUSY_BIT = 16;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_RSVD_BIT = 1;
  localparam logic [31:0] COMMAND_RESET = 32'h0000_0000;
  localparam logic [31:0] LAUNCH_RESET = 32'h0000_0000;

  // Operation classes and low codes
  localparam logic [2:0] CLASS_PRIMITIVE = 3'h0;
  localparam logic [2:0] CLASS_HIGH_LEVEL = 3'h3;
  localparam logic [2:0] CLASS_FIRST_RESERVED = 3'h4;
  localparam logic [3:0] PRIM_ADD = 4'h1;
  localparam logic [3:0] PRIM_SUB = 4'h2;
  localparam logic [3:0] PRIM_MUL = 4'h3;
  localparam logic [3:0] PRIM_DIV = 4'h4;
  localparam logic [3:0] PRIM_PLAIN_MUL = 4'h8;
  localparam logic [3:0] HL_ECMQV2 = 4'h0;
  localparam logic [3:0] HL_ZKP = 4'h1;
  localparam logic [3:0] HL_DOMAIN = 4'h2;

  // Execution timing defaults
  localparam int CYCLES_PER_WORD = 4;
  localparam int RECALC_CYCLES = 16;

  typedef enum logic [3:0] {
    OP_RESERVED, OP_MOD_ADD, OP_MOD_SUB, OP_MOD_MUL, OP_MOD_DIV, OP_MULT,
    OP_ECMQV2, OP_ZKP_VERIFY, OP_DOMAIN_CHECK
  } eccsc_op_t;

  typedef enum logic [1:0] {ST_IDLE, ST_RECALC, ST_EXEC} eccsc_state_t;

  typedef struct packed {
    logic recalc;
    logic signB;
    logic signA;
    logic [7:0] operandLength;
    logic fieldBinary;
    logic [6:0] operationCode;
  } eccsc_cmd_t;

  typedef struct packed {
    logic opStart;
    eccsc_op_t opKind;
    logic opFieldBinary;
    logic [7:0] opLength;
  } eccsc_launch_t;

endpackage : eccsc_pkg

// file: ecc_command_start_control_tb_top.sv
`timescale 1ns/10ps
module ecc_command_start_control_tb_top;
  localparam int CPW = 1;
  localparam int RCY = 2;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  eccsc_pkg::eccsc_launch_t opLaunch;
  logic busy;
  logic irq;
  int badCount = 0;
  int nCompared = 0;
  int busyCnt = 0;
  int startCnt = 0;
  logic [31:0] irqMask = 32'h0;
  logic [6:0] codes [14] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h08, 7'h09,
                             7'h30, 7'h31, 7'h32, 7'h33, 7'h40, 7'h7f};

  initial begin
    forever #20 mclk = ~mclk;
  end

  eccsc_ctrl #(.CYCLES_PER_WORD(CPW), .RECALC_CYCLES(RCY)) dut (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .opLaunch(opLaunch), .busy(busy), .irq(irq)
  );

  // Busy cycles and start pulses, sampled mid-cycle
  always @(negedge mclk) begin
    if (busy === 1'b1) busyCnt++;
    if (opLaunch.opStart === 1'b1) startCnt++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finishTest();
    $display("TB: %0d compared, %0d mismatched", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finishTest

  task automatic apb(input logic isWr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= isWr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Pready, read data and error taken at the edge that ends the access
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      badCount++;
      finishTest();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask : rdChk

  ////////////////////////////////////////////////////////////////////////////
  function automatic eccsc_pkg::eccsc_op_t expKind(input logic [6:0] c);
    case (c)
      7'h01: return eccsc_pkg::OP_MOD_ADD;
      7'h02: return eccsc_pkg::OP_MOD_SUB;
      7'h03: return eccsc_pkg::OP_MOD_MUL;
      7'h04: return eccsc_pkg::OP_MOD_DIV;
      7'h08: return eccsc_pkg::OP_MULT;
      7'h30: return eccsc_pkg::OP_ECMQV2;
      7'h31: return eccsc_pkg::OP_ZKP_VERIFY;
      7'h32: return eccsc_pkg::OP_DOMAIN_CHECK;
      default: return eccsc_pkg::OP_RESERVED;
    endcase
  endfunction : expKind

  function automatic int expCycles(input logic [31:0] cmd);
    int len;
    len = (cmd[15:8] == 8'h0) ? 1 : int'(cmd[15:8]);
    if (expKind(cmd[6:0]) == eccsc_pkg::OP_RESERVED) return 1;
    return len * CPW + (cmd[31] ? RCY : 0);
  endfunction : expCycles

  task automatic run(input logic [31:0] cmd, input logic retrig);
    eccsc_pkg::eccsc_op_t k;
    logic [31:0] st;
    logic [31:0] cur;
    int i;
    k = expKind(cmd[6:0]);
    st = (k == eccsc_pkg::OP_RESERVED) ? 32'h3 : 32'h1;
    cur = retrig ? (cmd ^ 32'h0000_0003) : cmd;
    wr(eccsc_pkg::ADDR_COMMAND, cmd);
    rdChk(eccsc_pkg::ADDR_COMMAND, cmd & 32'he000_ffff);
    busyCnt = 0;
    startCnt = 0;
    wr(eccsc_pkg::ADDR_LAUNCH, 32'h1);
    #1;
    check(32'(busy), 32'h1);
    check(32'(opLaunch.opKind), 32'(k));
    check(32'(opLaunch.opFieldBinary), 32'(cmd[7]));
    check(32'(opLaunch.opLength), 32'(cmd[15:8]));
    if (retrig) begin
      wr(eccsc_pkg::ADDR_COMMAND, cur);
      wr(eccsc_pkg::ADDR_LAUNCH, 32'h1);
      #1;
      check(32'(opLaunch.opKind), 32'(k));
    end
    for (i = 0; i < 400; i++) begin
      if (busy === 1'b0) break;
      @(posedge mclk);
      #1;
    end
    if (i == 400) begin
      badCount++;
      finishTest();
    end
    check(32'(busyCnt), 32'(expCycles(cmd)));
    check(32'(startCnt), 32'h1);
    check(32'(irq), 32'(|(st & irqMask)));
    rdChk(eccsc_pkg::ADDR_LAUNCH, 32'h0);
    rdChk(eccsc_pkg::ADDR_STATUS, 32'h0);
    rdChk(eccsc_pkg::ADDR_IRQ_STAT, st);
    rdChk(eccsc_pkg::ADDR_COMMAND, cur & 32'h6000_ffff);
    wr(eccsc_pkg::ADDR_IRQ_STAT, st);
    @(posedge mclk);
    #1;
    check(32'(irq), 32'h0);
    $display("TB: run of command %h done", cmd);
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic e;
    void'($urandom(32'h3be3be9f));
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    rdChk(eccsc_pkg::ADDR_COMMAND, 32'h0);
    rdChk(eccsc_pkg::ADDR_LAUNCH, 32'h0);
    rdChk(eccsc_pkg::ADDR_STATUS, 32'h0);
    rdChk(eccsc_pkg::ADDR_IRQ_STAT, 32'h0);
    rdChk(eccsc_pkg::ADDR_IRQ_MASK, 32'h0);
    apb(1'b0, 32'h5000_6000, 32'h0, r, e);
    check(r, 32'h0);
    check(32'(e), 32'h1);
    $display("TB: reset values done");
    irqMask = 32'h3;
    wr(eccsc_pkg::ADDR_IRQ_MASK, irqMask);
    rdChk(eccsc_pkg::ADDR_IRQ_MASK, 32'h3);
    foreach (codes[i]) begin
      run({1'b0, 2'($urandom), 13'h0, 8'($urandom_range(0, 5)), 1'($urandom), codes[i]}, 1'b0);
    end
    repeat (8) begin
      run({1'b0, 2'($urandom), 13'h0, 8'($urandom_range(0, 5)), 1'($urandom), 7'($urandom)}, 1'b0);
    end
    run(32'h8000_0203, 1'b0);
    run(32'h0000_1401, 1'b1);
    run(32'h0000_0082, 1'b0);
    irqMask = 32'h0;
    wr(eccsc_pkg::ADDR_IRQ_MASK, irqMask);
    run(32'h0000_0070, 1'b0);
    finishTest();
  end
endmodule : ecc_command_start_control_tb_top
